// File: vpc_pkg.sv
// constants and helpers for the vcxo pll control field bank
package vpc_pkg;
	// register indices as printed, byte address is four times the index
	localparam logic [7:0]  IDX_PLL_CTRL  = 8'h10;
	localparam logic [7:0]  IDX_OUT_CTRL  = 8'h11;
	localparam logic [11:0] ADDR_PLL_CTRL = {2'h0, IDX_PLL_CTRL, 2'h0};
	localparam logic [11:0] ADDR_OUT_CTRL = {2'h0, IDX_OUT_CTRL, 2'h0};

	localparam int POL_BIT   = 7;
	localparam int FORCE_BIT = 6;
	localparam int PUMP_LSB  = 0;
	localparam int PWR_BIT   = 7;
	localparam int FMT_BIT   = 6;
	localparam int OFSEN_BIT = 5;
	localparam int OFS_LSB   = 0;

	localparam logic       POL_RST   = 1'h0;
	localparam logic       FORCE_RST = 1'h1;
	localparam logic [4:0] PUMP_RST  = 5'h18;
	localparam logic       PWR_RST   = 1'h0;
	localparam logic       FMT_RST   = 1'h0;
	localparam logic       OFSEN_RST = 1'h0;
	localparam logic [4:0] OFS_RST   = 5'h00;

	localparam logic [10:0] PUMP_STEP_UA    = 11'h032;
	localparam logic [10:0] PUMP_RST_UA     = 11'h4e2;
	localparam logic [8:0]  OFS_STEP_TENTHS = 9'h009;

	// charge pump current in microamperes
	function automatic logic [10:0] pump_ua(input logic [4:0] code);
		return (11'(code) + 11'h001) * PUMP_STEP_UA;
	endfunction

	// phase offset in tenths of a degree
	function automatic logic [8:0] offset_tenths(input logic [4:0] code);
		return 9'(code) * OFS_STEP_TENTHS;
	endfunction
endpackage

// File: vpc_field_if.sv
// stored control fields passed from the register bank to the decoder
`timescale 1ns/1ps
`default_nettype none
interface vpc_field_if;
	logic       vcxo_polarity;
	logic       force_mid_control_voltage;
	logic [4:0] first_stage_pump_current;
	logic       osc_output_power_on;
	logic       osc_output_format;
	logic       phase_offset_enable;
	logic [4:0] phase_offset;

	modport bank (
		output vcxo_polarity, force_mid_control_voltage, first_stage_pump_current,
		output osc_output_power_on, osc_output_format, phase_offset_enable, phase_offset
	);
	modport dec (
		input vcxo_polarity, force_mid_control_voltage, first_stage_pump_current,
		input osc_output_power_on, osc_output_format, phase_offset_enable, phase_offset
	);
endinterface
`default_nettype wire

// File: vpc_field_decode.sv
// turns stored fields into registered analog control levels
`timescale 1ns/1ps
`default_nettype none
module vpc_field_decode (
	input  wire logic        pclk,
	input  wire logic        presetn,
	vpc_field_if.dec         fld,
	output logic             loop_sense_invert,
	output logic             vcxo_tuning_pin_mid,
	output logic [4:0]       pump_code,
	output logic [10:0]      pump_current_ua,
	output logic             oscillator_clock_output_on,
	output logic             oscillator_clock_output_ecl,
	output logic             pfd_offset_active,
	output logic [8:0]       pfd_offset_tenths
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_sense_invert           <= vpc_pkg::POL_RST;
			vcxo_tuning_pin_mid         <= vpc_pkg::FORCE_RST;
			pump_code                   <= vpc_pkg::PUMP_RST;
			pump_current_ua             <= vpc_pkg::PUMP_RST_UA;
			oscillator_clock_output_on  <= vpc_pkg::PWR_RST;
			oscillator_clock_output_ecl <= vpc_pkg::FMT_RST;
			pfd_offset_active           <= vpc_pkg::OFSEN_RST;
			pfd_offset_tenths           <= 9'h000;
		end else begin
			loop_sense_invert           <= fld.vcxo_polarity;
			vcxo_tuning_pin_mid         <= fld.force_mid_control_voltage;
			pump_code                   <= fld.first_stage_pump_current;
			pump_current_ua             <= vpc_pkg::pump_ua(fld.first_stage_pump_current);
			oscillator_clock_output_on  <= fld.osc_output_power_on;
			oscillator_clock_output_ecl <= fld.osc_output_format;
			pfd_offset_active           <= fld.phase_offset_enable;
			pfd_offset_tenths           <= fld.phase_offset_enable ? vpc_pkg::offset_tenths(fld.phase_offset) : 9'h000;
		end
	end
endmodule
`default_nettype wire

// File: vpc_bank.sv
// apb register bank for the vcxo pll control fields
//
// Operation
// - polarity bit one inverts the loop sense
// - force bit drives tuning pin to mid-supply
// - force bit resets to one
// - pump current is (code plus one) times 50uA
// - pump code resets to 11000, 1.25mA
// - output power bit resets off, one powers
// - format bit resets differential low-voltage, one ecl
// - offset enable gates the static offset
// - offset resets zero, 0.9 degree steps
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module vpc_bank (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             loop_sense_invert,
	output logic             vcxo_tuning_pin_mid,
	output logic [4:0]       pump_code,
	output logic [10:0]      pump_current_ua,
	output logic             oscillator_clock_output_on,
	output logic             oscillator_clock_output_ecl,
	output logic             pfd_offset_active,
	output logic [8:0]       pfd_offset_tenths
);
	vpc_field_if fld ();

	logic       hit_pll;
	logic       hit_out;
	logic       access;
	logic       wr_pll;
	logic       wr_out;
	logic [7:0] pll_word;
	logic [7:0] out_word;

	assign hit_pll = (paddr == vpc_pkg::ADDR_PLL_CTRL);
	assign hit_out = (paddr == vpc_pkg::ADDR_OUT_CTRL);
	assign access  = psel && penable;
	// only the low lane carries data; other lanes are ignored
	assign wr_pll  = access && pwrite && hit_pll && pstrb[0];
	assign wr_out  = access && pwrite && hit_out && pstrb[0];
	assign pready  = 1'b1;
	assign pslverr = access && !(hit_pll || hit_out);

	assign pll_word = {fld.vcxo_polarity, fld.force_mid_control_voltage, 1'b0, fld.first_stage_pump_current};
	assign out_word = {fld.osc_output_power_on, fld.osc_output_format, fld.phase_offset_enable, fld.phase_offset};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fld.vcxo_polarity             <= vpc_pkg::POL_RST;
			fld.force_mid_control_voltage <= vpc_pkg::FORCE_RST;
			fld.first_stage_pump_current  <= vpc_pkg::PUMP_RST;
		end else if (wr_pll) begin
			fld.vcxo_polarity             <= pwdata[vpc_pkg::POL_BIT];
			fld.force_mid_control_voltage <= pwdata[vpc_pkg::FORCE_BIT];
			fld.first_stage_pump_current  <= pwdata[vpc_pkg::PUMP_LSB +: 5];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fld.osc_output_power_on <= vpc_pkg::PWR_RST;
			fld.osc_output_format   <= vpc_pkg::FMT_RST;
			fld.phase_offset_enable <= vpc_pkg::OFSEN_RST;
			fld.phase_offset        <= vpc_pkg::OFS_RST;
		end else if (wr_out) begin
			fld.osc_output_power_on <= pwdata[vpc_pkg::PWR_BIT];
			fld.osc_output_format   <= pwdata[vpc_pkg::FMT_BIT];
			fld.phase_offset_enable <= pwdata[vpc_pkg::OFSEN_BIT];
			fld.phase_offset        <= pwdata[vpc_pkg::OFS_LSB +: 5];
		end
	end

	// read data captured in setup so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= hit_pll ? {24'h00_0000, pll_word} : hit_out ? {24'h00_0000, out_word} : 32'h0000_0000;
		end
	end

	vpc_field_decode u_dec (
		.pclk                        (pclk),
		.presetn                     (presetn),
		.fld                         (fld),
		.loop_sense_invert           (loop_sense_invert),
		.vcxo_tuning_pin_mid         (vcxo_tuning_pin_mid),
		.pump_code                   (pump_code),
		.pump_current_ua             (pump_current_ua),
		.oscillator_clock_output_on  (oscillator_clock_output_on),
		.oscillator_clock_output_ecl (oscillator_clock_output_ecl),
		.pfd_offset_active           (pfd_offset_active),
		.pfd_offset_tenths           (pfd_offset_tenths)
	);

	property p_polarity;
		@(posedge pclk) disable iff (!presetn) wr_pll |-> ##2 (loop_sense_invert == $past(pwdata[7], 2));
	endproperty
	a_polarity: assert property (p_polarity) else $error("loop sense not following polarity write");

	property p_force;
		@(posedge pclk) disable iff (!presetn) wr_pll |-> ##2 (vcxo_tuning_pin_mid == $past(pwdata[6], 2));
	endproperty
	a_force: assert property (p_force) else $error("tuning pin force not following write");

	property p_force_rst;
		@(posedge pclk) disable iff (!presetn) $rose(presetn) |-> (vcxo_tuning_pin_mid && fld.force_mid_control_voltage);
	endproperty
	a_force_rst: assert property (p_force_rst) else $error("force bit not set after reset");

	property p_pump;
		@(posedge pclk) disable iff (!presetn)
			1'b1 |=> (pump_current_ua == (11'($past(fld.first_stage_pump_current)) + 11'h001) * 11'h032);
	endproperty
	a_pump: assert property (p_pump) else $error("pump current not (code+1)*50");

	property p_pump_rst;
		@(posedge pclk) disable iff (!presetn) $rose(presetn) |-> (pump_code == 5'h18 && pump_current_ua == 11'h4e2);
	endproperty
	a_pump_rst: assert property (p_pump_rst) else $error("pump reset value wrong");

	property p_power;
		@(posedge pclk) disable iff (!presetn)
			($rose(presetn) |-> !oscillator_clock_output_on) and
			(wr_out |-> ##2 (oscillator_clock_output_on == $past(pwdata[7], 2)));
	endproperty
	a_power: assert property (p_power) else $error("output power state wrong");

	property p_format;
		@(posedge pclk) disable iff (!presetn)
			($rose(presetn) |-> !oscillator_clock_output_ecl) and
			(wr_out |-> ##2 (oscillator_clock_output_ecl == $past(pwdata[6], 2)));
	endproperty
	a_format: assert property (p_format) else $error("output format wrong");

	property p_ofs_gate;
		@(posedge pclk) disable iff (!presetn) !fld.phase_offset_enable |=> (pfd_offset_tenths == 9'h000 && !pfd_offset_active);
	endproperty
	a_ofs_gate: assert property (p_ofs_gate) else $error("offset applied while disabled");

	property p_ofs_val;
		@(posedge pclk) disable iff (!presetn)
			fld.phase_offset_enable |=> (pfd_offset_tenths == 9'($past(fld.phase_offset)) * 9'h009);
	endproperty
	a_ofs_val: assert property (p_ofs_val) else $error("offset not code*0.9 degree");

	property p_readback;
		@(posedge pclk) disable iff (!presetn)
			(psel && !penable && !pwrite && hit_pll) |=> (prdata == {24'h00_0000, $past(pll_word)});
	endproperty
	a_readback: assert property (p_readback) else $error("read data differs from stored fields");

	c_force_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(vcxo_tuning_pin_mid));
	c_ofs_on: cover property (@(posedge pclk) disable iff (!presetn) pfd_offset_active && pfd_offset_tenths != 9'h000);
	c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// File: vcxo_pll_control_fields_test.sv
// self-checking testbench for the vcxo pll control field bank
`timescale 1ns/1ps
`default_nettype none
module vcxo_pll_control_fields_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lsi, mid, on, ecl, act;
	logic [4:0]  code;
	logic [10:0] ua;
	logic [8:0]  tenths;
	wire  [29:0] outv;
	int          n_mismatch = 0;
	int          n_tests = 0;
	logic [7:0]  m0, m1, w0, w1;
	logic [31:0] d;
	logic        e;

	assign outv = {lsi, mid, code, ua, on, ecl, act, tenths};

	always #5 pclk = ~pclk;

	vpc_bank u_vpc_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.loop_sense_invert(lsi), .vcxo_tuning_pin_mid(mid), .pump_code(code), .pump_current_ua(ua),
		.oscillator_clock_output_on(on), .oscillator_clock_output_ecl(ecl), .pfd_offset_active(act),
		.pfd_offset_tenths(tenths));

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected bus value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [29:0] got, input logic [29:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected control outputs at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// expected analog controls from the two stored bytes
	function automatic logic [29:0] exp_out(input logic [7:0] a, input logic [7:0] b);
		logic [10:0] cur;
		logic [8:0]  ofs;
		cur = (11'(a[4:0]) + 11'h001) * 11'h032;
		ofs = b[5] ? 9'(b[4:0]) * 9'h009 : 9'h000;
		return {a[7], a[6], a[4:0], cur, b[7], b[6], b[5], ofs};
	endfunction

	// entered just after a rising edge, leaves just after one
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s,
		output logic [31:0] rd, output logic er);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			n_mismatch++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		apb(1'b0, a, 32'h0, 4'hf, d, e);
		chk_reg(d, exp);
		chk_reg({31'h0, e}, {31'h0, experr});
	endtask

	task automatic check_all;
		repeat (3) @(posedge pclk);
		chk_out(outv, exp_out(m0, m1));
		rd_chk(vpc_pkg::ADDR_PLL_CTRL, {24'h0, m0}, 1'b0);
		rd_chk(vpc_pkg::ADDR_OUT_CTRL, {24'h0, m1}, 1'b0);
	endtask

	initial begin
		void'($urandom(64));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		m0 = 8'h58;
		m1 = 8'h00;
		check_all();
		// corners first: pump extremes, offset max with enable on and off
		for (int i = 0; i < 24; i++) begin
			w0 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h9f : 8'($urandom);
			w1 = (i == 0) ? 8'hff : (i == 1) ? 8'h1f : (i == 2) ? 8'h3f : 8'($urandom);
			apb(1'b1, vpc_pkg::ADDR_PLL_CTRL, {24'($urandom), w0}, 4'hf, d, e);
			apb(1'b1, vpc_pkg::ADDR_OUT_CTRL, {24'($urandom), w1}, 4'hf, d, e);
			m0 = w0 & 8'hdf;
			m1 = w1;
			check_all();
		end
		// write without the low byte strobe is dropped
		apb(1'b1, vpc_pkg::ADDR_PLL_CTRL, ~{24'h0, m0}, 4'he, d, e);
		chk_reg({31'h0, e}, 32'h0);
		check_all();
		// unmapped place: error, reads zero, no field changes
		apb(1'b1, 12'h048, 32'hff, 4'hf, d, e);
		chk_reg({31'h0, e}, 32'h1);
		rd_chk(12'h03c, 32'h0, 1'b1);
		check_all();
		// reset in mid-run restores power-up fields
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		m0 = 8'h58;
		m1 = 8'h00;
		chk_out(outv, exp_out(m0, m1));
		check_all();
		end_of_test();
	end
endmodule
`default_nettype wire
